// ---- design/adc_fifo_defines.svh ----
`ifndef ADC_FIFO_DEFINES_SVH
`define ADC_FIFO_DEFINES_SVH

// register offsets
`define OFS_LOW_DATA_CHAN 8'h17
`define OFS_HIGH_DATA 8'h18
`define OFS_FLAGS 8'h19
`define OFS_IRQ_CTRL 8'h06
`define OFS_IRQ_CLEAR 8'h14

// flag positions
`define BIT_EMPTY 0
`define BIT_HALF 1
`define BIT_FULL 2
`define BIT_IRQ_EN 0

// geometry
`define FIFO_DEPTH 1024
`define RESULT_W 12
`define CHAN_W 4
`define LOW_NIB_W 4

`endif

// ---- design/adc_fifo_pkg.sv ----
package adc_fifo_pkg;

	typedef struct packed
	{
		logic [11:0] result;
		logic [3:0] channel;
	} fifo_entry_t;

	typedef enum logic [0:0]
	{
		RD_LOW = 1'b0,
		RD_HIGH = 1'b1
	} read_phase_t;

endpackage

// ---- design/adc_result_fifo.sv ----
`timescale 1ns/1ps
`include "adc_fifo_defines.svh"

module adc_result_fifo #(
	parameter int DEPTH = `FIFO_DEPTH,
	parameter int AW = $clog2(DEPTH)
)(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// conversion results
	input wire logic conv_valid_i,
	input wire logic [`RESULT_W-1:0] conversion_result_i,
	input wire logic [`CHAN_W-1:0] source_channel_i,
	output logic conv_ready_o,
	// host register port
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic rdata_valid_o,
	// interrupt to bus
	output logic buffer_irq_o
);

	localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
	localparam logic [AW:0] FULLC = (AW+1)'(DEPTH);

	typedef struct packed
	{
		adc_fifo_pkg::fifo_entry_t [1:0] skid;
		logic [1:0] skid_vld;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] count;
		adc_fifo_pkg::read_phase_t phase;
		logic buffer_irq_enable;
		logic irq_pend;
		logic irq_out;
		logic [7:0] rdata;
		logic rvalid;
		logic ready;
	} state_t;

	state_t s_q;
	state_t s_d;
	adc_fifo_pkg::fifo_entry_t mem [DEPTH];
	adc_fifo_pkg::fifo_entry_t head;
	adc_fifo_pkg::fifo_entry_t conv_entry;
	logic push;
	logic pop;
	logic flush;
	logic empty_flag;
	logic half_level_flag;
	logic full_flag;
	logic rd_low;
	logic rd_high;
	logic rd_flags;
	logic rd_ctrl;
	logic wr_ctrl;
	logic wr_irq_clear;
	logic conv_take;
	logic [7:0] low_view;
	logic [7:0] high_view;
	logic [7:0] flags_view;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// one stored entry from the converter inputs
	function automatic adc_fifo_pkg::fifo_entry_t pack_entry(
		input logic [`RESULT_W-1:0] r,
		input logic [`CHAN_W-1:0] c
	);
		pack_entry = '{result: r, channel: c};
	endfunction

	// lower port: low result nibble above the channel
	function automatic logic [7:0] low_byte(input adc_fifo_pkg::fifo_entry_t e);
		low_byte = {e.result[`LOW_NIB_W-1:0], e.channel};
	endfunction

	// upper port: the remaining eight result bits
	function automatic logic [7:0] high_byte(input adc_fifo_pkg::fifo_entry_t e);
		high_byte = e.result[`RESULT_W-1:`LOW_NIB_W];
	endfunction

	// status byte, unused bits read as zero
	function automatic logic [7:0] status_byte(input logic e, input logic h, input logic f);
		status_byte = 8'h00;
		status_byte[`BIT_EMPTY] = e;
		status_byte[`BIT_HALF] = h;
		status_byte[`BIT_FULL] = f;
	endfunction

	// pointers wrap at the store depth
	function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
		ptr_next = p + 1'h1;
	endfunction

	// fill level after this cycle's store write and entry advance
	function automatic logic [AW:0] count_next(input logic [AW:0] c, input logic up, input logic down);
		count_next = c;
		if (up && !down)
		begin
			count_next = c + 1'h1;
		end
		else if (down && !up)
		begin
			count_next = c - 1'h1;
		end
	endfunction

	// reset value: empty store, ready to accept, interrupt disabled
	function automatic state_t reset_state();
		state_t r;
		r.skid = '0;
		r.skid_vld = '0;
		r.wptr = '0;
		r.rptr = '0;
		r.count = '0;
		r.phase = adc_fifo_pkg::RD_LOW;
		r.buffer_irq_enable = 1'h0;
		r.irq_pend = 1'h0;
		r.irq_out = 1'h0;
		r.rdata = '0;
		r.rvalid = 1'h0;
		r.ready = 1'h1;
		return r;
	endfunction

	assign head = mem[s_q.rptr];
	assign empty_flag = (s_q.count == '0);
	assign full_flag = (s_q.count == FULLC);
	assign half_level_flag = (s_q.count >= HALF);

	// byte views of the head entry and of the flags
	assign low_view = low_byte(head);
	assign high_view = high_byte(head);
	assign flags_view = status_byte(empty_flag, half_level_flag, full_flag);
	assign conv_entry = pack_entry(conversion_result_i, source_channel_i);

	// register decode, one strobe per port and direction
	assign rd_low = rd_i && hit(addr_i, `OFS_LOW_DATA_CHAN);
	assign rd_high = rd_i && hit(addr_i, `OFS_HIGH_DATA);
	assign rd_flags = rd_i && hit(addr_i, `OFS_FLAGS);
	assign rd_ctrl = rd_i && hit(addr_i, `OFS_IRQ_CTRL);
	assign wr_ctrl = wr_i && hit(addr_i, `OFS_IRQ_CTRL);
	assign wr_irq_clear = wr_i && hit(addr_i, `OFS_IRQ_CLEAR);
	assign flush = wr_i && hit(addr_i, `OFS_FLAGS);
	assign conv_take = conv_valid_i && s_q.ready;

	// skid head drains into the store while there is room
	assign push = s_q.skid_vld[0] && !full_flag && !flush;
	// entry advances only after its lower and then its upper byte were read
	assign pop = rd_high && (s_q.phase == adc_fifo_pkg::RD_HIGH) && !empty_flag && !flush;

	always_comb
	begin
		s_d = s_q;
		s_d.rvalid = 1'h0;

		// two-entry skid buffer ahead of the store
		if (push)
		begin
			s_d.skid[0] = s_q.skid[1];
			s_d.skid_vld = {1'h0, s_q.skid_vld[1]};
		end
		if (conv_take)
		begin
			if (!s_d.skid_vld[0])
			begin
				s_d.skid[0] = conv_entry;
				s_d.skid_vld[0] = 1'h1;
			end
			else
			begin
				s_d.skid[1] = conv_entry;
				s_d.skid_vld[1] = 1'h1;
			end
		end
		// ready is registered, so it must leave room for the word taken next cycle
		s_d.ready = !s_d.skid_vld[1];

		// store pointers and fill level; skid contents survive a flush
		if (flush)
		begin
			s_d.wptr = '0;
			s_d.rptr = '0;
			s_d.count = '0;
			s_d.phase = adc_fifo_pkg::RD_LOW;
		end
		else
		begin
			if (push)
			begin
				s_d.wptr = ptr_next(s_q.wptr);
			end
			if (pop)
			begin
				s_d.rptr = ptr_next(s_q.rptr);
			end
			s_d.count = count_next(s_q.count, push, pop);
		end

		// interrupt: pending on every stored entry, a store wins over a clear
		if (wr_ctrl)
		begin
			s_d.buffer_irq_enable = wdata_i[`BIT_IRQ_EN];
		end
		if (push)
		begin
			s_d.irq_pend = 1'h1;
		end
		else if (wr_irq_clear)
		begin
			s_d.irq_pend = 1'h0;
		end
		s_d.irq_out = s_d.irq_pend && s_d.buffer_irq_enable;

		// read port, data registered and held until the next read
		if (rd_i)
		begin
			s_d.rvalid = 1'h1;
			s_d.rdata = 8'h00;
			if (rd_low)
			begin
				s_d.rdata = low_view;
				s_d.phase = adc_fifo_pkg::RD_HIGH;
			end
			else if (rd_high)
			begin
				s_d.rdata = high_view;
				if (!flush)
				begin
					s_d.phase = adc_fifo_pkg::RD_LOW;
				end
			end
			else if (rd_flags)
			begin
				s_d.rdata = flags_view;
			end
			else if (rd_ctrl)
			begin
				s_d.rdata[`BIT_IRQ_EN] = s_q.buffer_irq_enable;
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			s_q <= reset_state();
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// store array has no reset: empty is told by the fill level alone
	always_ff @(posedge ref_clk_i)
	begin
		if (push)
		begin
			mem[s_q.wptr] <= s_q.skid[0];
		end
	end

	assign conv_ready_o = s_q.ready;
	assign rdata_o = s_q.rdata;
	assign rdata_valid_o = s_q.rvalid;
	assign buffer_irq_o = s_q.irq_out;

endmodule

// ---- sim/adc_fifo_monitor.sv ----
`timescale 1ns/1ps
module adc_fifo_monitor (
	input logic ref_clk_i,
	input logic rst_n_i,
	input logic conv_ready_o,
	input logic [7:0] addr_i,
	input logic rd_i,
	input logic [7:0] rdata_o,
	input logic rdata_valid_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_stat; rd_i && addr_i == 8'h19; endsequence
	a_rdv_pulse: assert property (rd_i |=> rdata_valid_o) else $error("no answer");
	a_rdv_idle: assert property (!rd_i |=> !rdata_valid_o) else $error("stray");
	a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o)) else $error("moved");
	a_unmapped_zero: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00) else $error("unmapped");
	a_stat_pad: assert property (s_stat |=> rdata_o[7:3] == 5'h00) else $error("pad");
	a_empty_half: assert property (s_stat |=> !(rdata_o[0] && rdata_o[1])) else $error("empty");
	a_full_half: assert property (s_stat |=> !rdata_o[2] || rdata_o[1]) else $error("full");
	a_ready_rst: assert property ($rose(rst_n_i) |-> conv_ready_o) else $error("ready");
endmodule
bind adc_result_fifo adc_fifo_monitor mon (.ref_clk_i, .rst_n_i, .conv_ready_o, .addr_i, .rd_i, .rdata_o, .rdata_valid_o);

// ---- sim/host_model.sv ----
`timescale 1ns/1ps
module host_model (
	input logic ref_clk_i,
	input logic [7:0] rdata_i,
	output logic [7:0] addr_o = 8'h00,
	output logic rd_o = 1'h0,
	output logic wr_o = 1'h0,
	output logic [7:0] wdata_o = 8'h00
);
	// one strobe cycle; address scrambled once released
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge ref_clk_i);
		{rd_o, wr_o, addr_o, wdata_o} = {!w, w, a, d};
		@(negedge ref_clk_i);
		{rd_o, wr_o, addr_o} = {2'h0, ~a};
		q = rdata_i;
	endtask
endmodule

// ---- sim/adc_result_fifo_tb.sv ----
`timescale 1ns/1ps
module adc_result_fifo_tb;
	localparam int DEPTH = 4;
	logic ref_clk_i = 0, rst_n_i = 0, conv_valid_i = 0, conv_ready_o, rd_i, wr_i, buffer_irq_o;
	logic [15:0] ent = 16'h0000;
	logic [7:0] addr_i, wdata_i, rdata_o, q;
	int n_mismatch = 0, checks_done = 0, seed = 32'h9c83, fq[$];
	always #10 ref_clk_i = ~ref_clk_i;
	adc_result_fifo #(.DEPTH(DEPTH), .AW(2)) uut (.ref_clk_i, .rst_n_i, .conv_valid_i, .conversion_result_i(ent[15:4]),
		.source_channel_i(ent[3:0]), .conv_ready_o, .addr_i, .rd_i, .wr_i, .wdata_i, .rdata_o, .rdata_valid_o(),
		.buffer_irq_o);
	host_model host (.ref_clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .rd_o(rd_i), .wr_o(wr_i), .wdata_o(wdata_i));
	task chk(input string n, input logic [7:0] e, s);
		checks_done++;
		if (s !== e)
		begin
			$display("BAD %s exp %h got %h", n, e, s);
			n_mismatch++;
		end
	endtask
	task push;
		@(negedge ref_clk_i);
		if (conv_ready_o === 1'h1)
		begin
			ent = 16'($random(seed));
			conv_valid_i = 1'h1;
			fq.push_back(ent);
		end
		@(negedge ref_clk_i);
		conv_valid_i = 1'h0;
	endtask
	task flags;
		repeat (3) @(negedge ref_clk_i);
		host.acc(0, 8'h19, 8'h00, q);
		chk("flags", {5'h00, fq.size() >= DEPTH, fq.size() >= DEPTH / 2, fq.size() == 0}, q);
	endtask
	task complete_run;
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(negedge ref_clk_i);
		rst_n_i = 1;
		flags;
		host.acc(1, 8'h06, 8'h01, q);
		host.acc(0, 8'h06, 8'h00, q);
		chk("irq_ctrl", 8'h01, q);
		repeat (7) push;
		chk("irq", 8'h01, 8'(buffer_irq_o));
		host.acc(1, 8'h14, 8'h00, q);
		chk("irq", 8'h00, 8'(buffer_irq_o));
		flags;
		host.acc(0, 8'h18, 8'h00, q);
		chk("upper", 8'(fq[0] >> 8), q);
		while (fq.size() > 0)
		begin
			host.acc(0, 8'h17, 8'h00, q);
			chk("lower", 8'(fq[0]), q);
			host.acc(0, 8'h18, 8'h00, q);
			chk("upper", 8'(fq.pop_front() >> 8), q);
			flags;
		end
		push;
		push;
		chk("irq", 8'h01, 8'(buffer_irq_o));
		host.acc(1, 8'h06, 8'h00, q);
		chk("irq", 8'h00, 8'(buffer_irq_o));
		host.acc(1, 8'h19, 8'hA5, q);
		fq = {};
		flags;
		host.acc(0, 8'h00, 8'h00, q);
		complete_run;
	end
	initial
	begin
		#100000;
		n_mismatch++;
		complete_run;
	end
endmodule
